// ==== design/led_status_pkg.sv ====
// constants shared by the led matrix status registers and the bus stuck monitor
// assumes one 40 mhz core clock and byte-wide register data
package led_status_pkg;
    // ==========================================================================
    // register offsets
    localparam logic [7:0] TEST_CTRL_OFFSET   = 8'h09;
    localparam logic [7:0] BUS_MON_OFFSET     = 8'h0b;
    localparam logic [7:0] FAULT_RESULT_OFFSET = 8'h0c;
    localparam logic [7:0] STATE_REPORT_OFFSET = 8'h0d;

    // ==========================================================================
    // reset values
    localparam logic [7:0] TEST_CTRL_RESET    = 8'h00;
    localparam logic [7:0] BUS_MON_RESET      = 8'hff;
    localparam logic [7:0] FAULT_RESULT_RESET = 8'h00;
    localparam logic [7:0] STATE_REPORT_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    // ==========================================================================
    // field positions
    localparam int TEST_START_BIT   = 0;
    localparam int TEST_FULL_BIT    = 1;
    localparam int MON_ENABLE_BIT   = 0;
    localparam int MON_WINDOW_LSB   = 1;
    localparam int MON_WINDOW_W     = 7;
    localparam int FAULT_RUN_BIT    = 6;
    localparam int FAULT_SHORT_LSB  = 3;
    localparam int FAULT_OPEN_LSB   = 0;
    localparam int MATRIX_COUNT     = 3;
    localparam int MOVIE_BIT        = 6;
    localparam int IRQ_POR_BIT      = 4;
    localparam int IRQ_MON_BIT      = 5;
    localparam int FRAME_LSB        = 0;
    localparam int FRAME_W          = 4;

    // ==========================================================================
    // timing
    localparam int CLK_MHZ          = 40;
    localparam int MON_UNIT_US      = 256;
    localparam int MON_UNIT_CYCLES  = MON_UNIT_US * CLK_MHZ;
endpackage

// ==== design/bus_stuck_monitor.sv ====
// counts how long the serial data line stays low and pulses on timeout
// assumes sda_in is already synchronous to core_clk
`timescale 1ns/1ps
module bus_stuck_monitor #(
    parameter int UNIT_CYCLES = 10240,
    parameter int WINDOW_W    = 7
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                enable,
    input  wire logic [WINDOW_W-1:0] window,
    input  wire logic                sda_in,
    output logic                     timeout
);
    localparam int PRE_W = $clog2(UNIT_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);

    logic [PRE_W-1:0]    pre_reg;
    logic [PRE_W-1:0]    pre_next;
    logic [WINDOW_W-1:0] unit_reg;
    logic [WINDOW_W-1:0] unit_next;
    logic                timeout_reg;
    logic                timeout_next;

    // ==========================================================================
    // window of (window + 1) units of low time
    always_comb begin
        pre_next     = pre_reg;
        unit_next    = unit_reg;
        timeout_next = 1'b0;
        if (!enable || sda_in) begin
            pre_next  = '0;
            unit_next = '0;
        end else if (pre_reg == PRE_LAST) begin
            pre_next = '0;
            if (unit_reg == window) begin
                unit_next    = '0;
                timeout_next = 1'b1;
            end else begin
                unit_next = unit_reg + 1'b1;
            end
        end else begin
            pre_next = pre_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_reg     <= '0;
            unit_reg    <= '0;
            timeout_reg <= 1'b0;
        end else begin
            pre_reg     <= pre_next;
            unit_reg    <= unit_next;
            timeout_reg <= timeout_next;
        end
    end

    assign timeout = timeout_reg;
endmodule // bus_stuck_monitor

// ==== design/led_matrix_status_registers.sv ====
// status register bank of an led matrix driver: fault result, state report,
// test control and bus monitor setup, behind the serial slave's register port
// assumes the serial slave engine gives one-cycle read and write strobes,
// and the diagnostic engine and sequencer signals are synchronous to core_clk
`timescale 1ns/1ps
module led_matrix_status_registers
    import led_status_pkg::*;
#(
    parameter int UNIT_CYCLES = MON_UNIT_CYCLES
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    rd_en,
    input  wire logic [7:0]              rd_addr,
    input  wire logic                    wr_en,
    input  wire logic [7:0]              wr_addr,
    input  wire logic [7:0]              wr_data,
    input  wire logic                    diag_done,
    input  wire logic [MATRIX_COUNT-1:0] diag_short,
    input  wire logic [MATRIX_COUNT-1:0] diag_open,
    input  wire logic                    movie_playing,
    input  wire logic [FRAME_W-1:0]      frame_index,
    input  wire logic                    sda_in,
    output logic [7:0]                   rd_data,
    output logic                         rd_valid,
    output logic                         test_start,
    output logic                         full_matrix,
    output logic                         if_reset
);
    logic [7:0]              test_ctrl_reg;
    logic [7:0]              test_ctrl_next;
    logic [7:0]              bus_mon_reg;
    logic [7:0]              bus_mon_next;
    logic                    running_reg;
    logic                    running_next;
    logic [MATRIX_COUNT-1:0] short_reg;
    logic [MATRIX_COUNT-1:0] short_next;
    logic [MATRIX_COUNT-1:0] open_reg;
    logic [MATRIX_COUNT-1:0] open_next;
    logic                    por_pending_reg;
    logic                    por_pending_next;
    logic                    irq_por_reg;
    logic                    irq_por_next;
    logic                    irq_mon_reg;
    logic                    irq_mon_next;
    logic [7:0]              rd_data_reg;
    logic [7:0]              rd_data_next;
    logic                    rd_valid_reg;
    logic                    rd_valid_next;
    logic                    test_start_reg;
    logic                    test_start_next;
    logic                    if_reset_reg;
    logic                    if_reset_next;
    logic                    mon_timeout;
    logic                    start_req;
    logic                    report_read;
    logic [7:0]              fault_word;
    logic [7:0]              report_word;

    // ==========================================================================
    // bus stuck monitor
    bus_stuck_monitor #(
        .UNIT_CYCLES (UNIT_CYCLES),
        .WINDOW_W    (MON_WINDOW_W)
    ) u_monitor (
        .core_clk (core_clk),
        .rst      (rst),
        .enable   (bus_mon_reg[MON_ENABLE_BIT]),
        .window   (bus_mon_reg[MON_WINDOW_LSB +: MON_WINDOW_W]),
        .sda_in   (sda_in),
        .timeout  (mon_timeout)
    );

    // ==========================================================================
    // read words
    always_comb begin
        fault_word = FAULT_RESULT_RESET;
        fault_word[FAULT_RUN_BIT] = running_reg;
        fault_word[FAULT_SHORT_LSB +: MATRIX_COUNT] = short_reg;
        fault_word[FAULT_OPEN_LSB +: MATRIX_COUNT] = open_reg;
        report_word = STATE_REPORT_RESET;
        report_word[MOVIE_BIT] = movie_playing;
        report_word[IRQ_POR_BIT] = irq_por_reg;
        report_word[IRQ_MON_BIT] = irq_mon_reg;
        report_word[FRAME_LSB +: FRAME_W] = frame_index;
    end

    // ==========================================================================
    // register port and status state
    always_comb begin
        start_req   = wr_en && (wr_addr == TEST_CTRL_OFFSET) && !wr_data[TEST_START_BIT];
        report_read = rd_en && (rd_addr == STATE_REPORT_OFFSET);
        test_ctrl_next   = test_ctrl_reg;
        bus_mon_next     = bus_mon_reg;
        running_next     = running_reg;
        short_next       = short_reg;
        open_next        = open_reg;
        por_pending_next = 1'b0;
        irq_por_next     = irq_por_reg;
        irq_mon_next     = irq_mon_reg;
        rd_data_next     = rd_data_reg;
        rd_valid_next    = rd_en;
        test_start_next  = start_req;
        if_reset_next    = mon_timeout;

        if (wr_en && (wr_addr == TEST_CTRL_OFFSET)) begin
            test_ctrl_next = wr_data;
        end
        if (wr_en && (wr_addr == BUS_MON_OFFSET)) begin
            bus_mon_next = wr_data;
        end

        // results and running flag move together so a poll never sees stale bits
        if (diag_done) begin
            short_next   = diag_short;
            open_next    = diag_open;
            running_next = 1'b0;
        end
        if (start_req) begin
            running_next = 1'b1;
        end

        if (rd_en) begin
            case (rd_addr)
                TEST_CTRL_OFFSET:    rd_data_next = test_ctrl_reg;
                BUS_MON_OFFSET:      rd_data_next = bus_mon_reg;
                FAULT_RESULT_OFFSET: rd_data_next = fault_word;
                STATE_REPORT_OFFSET: rd_data_next = report_word;
                default:             rd_data_next = UNMAPPED_READ;
            endcase
        end

        // clear on read first, so a new cause in the same cycle still sets
        if (report_read) begin
            irq_por_next = 1'b0;
            irq_mon_next = 1'b0;
        end
        if (por_pending_reg) begin
            irq_por_next = 1'b1;
        end
        if (mon_timeout) begin
            irq_mon_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            test_ctrl_reg   <= TEST_CTRL_RESET;
            bus_mon_reg     <= BUS_MON_RESET;
            running_reg     <= FAULT_RESULT_RESET[FAULT_RUN_BIT];
            short_reg       <= '0;
            open_reg        <= '0;
            por_pending_reg <= 1'b1;
            irq_por_reg     <= 1'b0;
            irq_mon_reg     <= 1'b0;
            rd_data_reg     <= 8'h00;
            rd_valid_reg    <= 1'b0;
            test_start_reg  <= 1'b0;
            if_reset_reg    <= 1'b0;
        end else begin
            test_ctrl_reg   <= test_ctrl_next;
            bus_mon_reg     <= bus_mon_next;
            running_reg     <= running_next;
            short_reg       <= short_next;
            open_reg        <= open_next;
            por_pending_reg <= por_pending_next;
            irq_por_reg     <= irq_por_next;
            irq_mon_reg     <= irq_mon_next;
            rd_data_reg     <= rd_data_next;
            rd_valid_reg    <= rd_valid_next;
            test_start_reg  <= test_start_next;
            if_reset_reg    <= if_reset_next;
        end
    end

    // ==========================================================================
    // outputs
    assign rd_data     = rd_data_reg;
    assign rd_valid    = rd_valid_reg;
    assign test_start  = test_start_reg;
    assign full_matrix = test_ctrl_reg[TEST_FULL_BIT];
    assign if_reset    = if_reset_reg;
endmodule // led_matrix_status_registers

// ==== bench/led_status_monitor.sv ====
// concurrent checks on the status register bank ports
// assumes the single core_clk domain with rst asynchronous, active high
`timescale 1ns/1ps
module led_status_monitor
    import led_status_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic       wr_en,
    input wire logic       diag_done,
    input wire logic [2:0] diag_short,
    input wire logic [2:0] diag_open,
    input wire logic       movie_playing,
    input wire logic [3:0] frame_index,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic       test_start,
    input wire logic       if_reset
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ====
    // access sequences
    sequence rd_fault; rd_en && rd_addr == FAULT_RESULT_OFFSET; endsequence
    sequence rd_state; rd_en && rd_addr == STATE_REPORT_OFFSET; endsequence
    sequence done_free; diag_done && !wr_en && !test_start; endsequence
    // ====
    // checks
    read_answer_a:
        assert property (rd_en |=> rd_valid) else $error("read left unanswered");
    fault_top_a:
        assert property (rd_fault |=> !rd_data[7]) else $error("fault result bit 7 set");
    run_flag_a:
        assert property (test_start ##0 rd_fault |=> rd_data[FAULT_RUN_BIT]) else $error("running flag low");
    result_load_a:
        assert property (done_free ##1 rd_fault |=> rd_data[6:0] == {1'b0, $past(diag_short, 2), $past(diag_open, 2)})
            else $error("fault results wrong after done");
    state_live_a:
        assert property (rd_state |=> !rd_data[7] && rd_data[6] == $past(movie_playing)
            && rd_data[3:0] == $past(frame_index)) else $error("state report live bits wrong");
    // the power-up cause lands one edge after release, so a read on that edge does not clear it
    read_clear_a:
        assert property ((!$past(rst) ##0 rd_state) ##1 (!if_reset ##0 rd_state) |=> rd_data[5:4] == 2'b00)
            else $error("cause not cleared");
    por_cause_a:
        assert property ($fell(rst) ##1 !(rd_en && rd_addr == STATE_REPORT_OFFSET) ##1 rd_state
            |=> rd_data[IRQ_POR_BIT]) else $error("power-up cause missing");
    mon_cause_a:
        assert property (if_reset ##0 rd_state |=> rd_data[IRQ_MON_BIT]) else $error("monitor cause missing");
endmodule // led_status_monitor

bind led_matrix_status_registers led_status_monitor led_status_monitor_inst (
    .core_clk(core_clk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .diag_done(diag_done),
    .diag_short(diag_short), .diag_open(diag_open), .movie_playing(movie_playing), .frame_index(frame_index),
    .rd_data(rd_data), .rd_valid(rd_valid), .test_start(test_start), .if_reset(if_reset)
);

// ==== bench/diag_engine_model.sv ====
// diagnostic engine stand-in: answers a start pulse with done and results lat + 1 cycles after the edge that samples it
// assumes test_start is a one-cycle pulse synchronous to core_clk
`timescale 1ns/1ps
module diag_engine_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       test_start,
    input  wire logic [7:0] lat,
    input  wire logic [2:0] res_short,
    input  wire logic [2:0] res_open,
    output logic            diag_done,
    output logic [2:0]      diag_short,
    output logic [2:0]      diag_open
);
    logic [7:0] left_reg;
    logic       busy_reg;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            left_reg <= 8'h00;
            diag_done <= 1'b0;
        end else begin
            diag_done <= busy_reg && left_reg == 8'h00 && !test_start;
            if (test_start) begin
                busy_reg <= 1'b1;
                left_reg <= lat;
            end else if (busy_reg) begin
                busy_reg <= left_reg != 8'h00;
                left_reg <= left_reg - 8'h01;
            end
        end
    end
    // results carry garbage outside the done pulse
    assign diag_short = diag_done ? res_short : ~res_short;
    assign diag_open = diag_done ? res_open : ~res_open;
endmodule // diag_engine_model

// ==== bench/led_matrix_status_registers_bench.sv ====
// self-checking bench: strobe-port reads and writes, engine model on the far side
// assumes package, design, monitor and engine model compiled first
`timescale 1ns/1ps
module led_matrix_status_registers_bench
    import led_status_pkg::*;
;
    localparam int UNITS = 4;
    logic       core_clk = 1'b0, rst = 1'b1, rd_en = 1'b0, wr_en = 1'b0, movie_playing = 1'b0, sda_in = 1'b1;
    logic       diag_done, rd_valid, test_start, full_matrix, if_reset;
    logic [7:0] rd_addr = 8'h00, wr_addr = 8'h00, wr_data = 8'h00, lat = 8'h00, last = 8'h00, rd_data;
    logic [3:0] frame_index = 4'h0;
    logic [2:0] res_short = 3'h0, res_open = 3'h0, diag_short, diag_open;
    logic [5:0] pat [3] = '{6'h2a, 6'h15, 6'h3f};
    int         bad_count = 0, n_tests = 0, k;
    initial forever #12.5 core_clk = ~core_clk;
    led_matrix_status_registers #(.UNIT_CYCLES(UNITS)) led_matrix_status_registers_inst (
        .core_clk(core_clk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .diag_done(diag_done), .diag_short(diag_short), .diag_open(diag_open),
        .movie_playing(movie_playing), .frame_index(frame_index), .sda_in(sda_in), .rd_data(rd_data),
        .rd_valid(rd_valid), .test_start(test_start), .full_matrix(full_matrix), .if_reset(if_reset));
    diag_engine_model diag_engine_model_inst (.core_clk(core_clk), .rst(rst), .test_start(test_start),
        .lat(lat), .res_short(res_short), .res_open(res_open), .diag_done(diag_done),
        .diag_short(diag_short), .diag_open(diag_open));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input logic r, input logic w);
        rd_en = r;
        wr_en = w;
        @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_addr = a;
        step(1'b1, 1'b0);
        chk("rd_valid", 8'h01, {7'h00, rd_valid});
        chk("rd_data", exp, rd_data);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_addr = a;
        wr_data = d;
        step(1'b0, 1'b1);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'b0;
        rd(FAULT_RESULT_OFFSET, FAULT_RESULT_RESET);
        rd(8'h0e, UNMAPPED_READ);
        rd(STATE_REPORT_OFFSET, 8'h10);
        rd(STATE_REPORT_OFFSET, STATE_REPORT_RESET);
        rd(TEST_CTRL_OFFSET, TEST_CTRL_RESET);
        rd(BUS_MON_OFFSET, BUS_MON_RESET);
        wr(FAULT_RESULT_OFFSET, 8'hff);
        rd(FAULT_RESULT_OFFSET, FAULT_RESULT_RESET);
        wr(TEST_CTRL_OFFSET, 8'h03);
        chk("test_start", 8'h00, {7'h00, test_start});
        chk("full_matrix", 8'h01, {7'h00, full_matrix});
        chk("rd_valid idle", 8'h00, {7'h00, rd_valid});
        for (int i = 0; i < 3; i++) begin
            lat = 8'(2 + 20 * i);
            {res_short, res_open} = pat[i];
            wr(TEST_CTRL_OFFSET, 8'h00);
            chk("test_start", 8'h01, {7'h00, test_start});
            chk("full_matrix", 8'h00, {7'h00, full_matrix});
            rd(FAULT_RESULT_OFFSET, 8'h40 | last);
            for (k = 0; k < 100 && diag_done !== 1'b1; k++) step(1'b0, 1'b0);
            chk("diag_done", 8'h01, {7'h00, diag_done});
            if (diag_done !== 1'b1) stop_test();
            last = {2'b00, pat[i]};
            step(1'b0, 1'b0);
            rd(FAULT_RESULT_OFFSET, last);
        end
        for (int i = 0; i < 6; i++) begin
            frame_index = 4'(i);
            movie_playing = i[0];
            rd(STATE_REPORT_OFFSET, {1'b0, i[0], 2'b00, 4'(i)});
        end
        wr(BUS_MON_OFFSET, 8'h05);
        sda_in = 1'b0;
        for (k = 0; k < 30 && if_reset !== 1'b1; k++) step(1'b0, 1'b0);
        chk("if_reset delay", 8'h01, {7'h00, k >= 3 * UNITS && k <= 3 * UNITS + 4});
        if (k == 30) stop_test();
        rd(STATE_REPORT_OFFSET, 8'h65);
        sda_in = 1'b1;
        rd(STATE_REPORT_OFFSET, 8'h45);
        wr(BUS_MON_OFFSET, 8'h04);
        sda_in = 1'b0;
        k = 0;
        repeat (40) begin
            step(1'b0, 1'b0);
            if (if_reset !== 1'b0) k++;
        end
        chk("if_reset count", 8'h00, 8'(k));
        // second start-up in mid-run: the power-up cause must come back
        rst = 1'b1;
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        rst = 1'b0;
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        rd(STATE_REPORT_OFFSET, 8'h55);
        rd(FAULT_RESULT_OFFSET, FAULT_RESULT_RESET);
        rd(BUS_MON_OFFSET, BUS_MON_RESET);
        stop_test();
    end
endmodule // led_matrix_status_registers_bench
